// ---- hw/lds_pkg.sv ----
/*
 * shared constants and carrier types for the led dimming and sleep control block.
 * assumes a single 100 MHz clock domain and a synchronous active-high reset.
 */
package lds_pkg;
    // ------------------------------------------------------------
    // sizing
    // ------------------------------------------------------------
    localparam int NUM_GPIO = 10;
    localparam int GPIO_IDX_W = 4;
    localparam int DUTY_W = 4;
    localparam logic [3:0] DUTY_PERIOD = 4'hf;
    localparam int CLK_HZ = 100000000;

    // ------------------------------------------------------------
    // sleep intervals, ticks of the wake timer
    // ------------------------------------------------------------
    localparam int SLEEP_HZ_512 = 512;
    localparam int SLEEP_HZ_64 = 64;
    localparam int SLEEP_HZ_8 = 8;
    localparam int SLEEP_HZ_1 = 1;
    localparam int SLEEP_CYC_512 = CLK_HZ / SLEEP_HZ_512;
    localparam int SLEEP_CYC_64 = CLK_HZ / SLEEP_HZ_64;
    localparam int SLEEP_CYC_8 = CLK_HZ / SLEEP_HZ_8;
    localparam int SLEEP_CYC_1 = CLK_HZ / SLEEP_HZ_1;
    localparam int SLEEP_CNT_W = 27;

    // sleep interval select codes
    localparam logic [1:0] SLP_SEL_512 = 2'h0;
    localparam logic [1:0] SLP_SEL_64 = 2'h1;
    localparam logic [1:0] SLP_SEL_8 = 2'h2;
    localparam logic [1:0] SLP_SEL_1 = 2'h3;

    // ------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LDS_DIM_FOLLOW = 2'h0,
        LDS_DIM_FLASH = 2'h1,
        LDS_DIM_HOLD = 2'h2,
        LDS_DIM_TOGGLE = 2'h3
    } lds_dim_e;

    typedef enum logic [3:0] {
        LDS_ST_ACTIVE = 4'h1,
        LDS_ST_SLEEP = 4'h2,
        LDS_ST_SCAN = 4'h4,
        LDS_ST_DEEP = 4'h8
    } lds_state_e;

    // ------------------------------------------------------------
    // configuration carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_GPIO-1:0] pwm_en;
        logic [NUM_GPIO-1:0] static_high;
        logic [NUM_GPIO-1:0] use_pwm;
        logic [DUTY_W-1:0] duty;
        lds_dim_e dim_mode;
        logic sleep_en;
        logic deep_en;
        logic [1:0] sleep_sel;
        logic sctl_en;
        logic [GPIO_IDX_W-1:0] sctl_pin;
        logic sctl_irq_en;
        logic [6:0] i2c_addr;
        logic i2c_addr_lock;
    } lds_cfg_s;

    localparam logic [6:0] I2C_ADDR_RESET = 7'h00;
endpackage : lds_pkg

// ---- hw/lds_wake_timer.sv ----
/*
 * wake interval timer for periodic sleep.
 * assumes the caller holds i_run high only while sleeping; counter restarts otherwise.
 */
`timescale 1ns/1ps
`default_nettype none
module lds_wake_timer #(
    parameter int CYC_512 = lds_pkg::SLEEP_CYC_512,
    parameter int CYC_64 = lds_pkg::SLEEP_CYC_64,
    parameter int CYC_8 = lds_pkg::SLEEP_CYC_8,
    parameter int CYC_1 = lds_pkg::SLEEP_CYC_1
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_run,
    input wire logic [1:0] i_sel,
    output logic o_tick
);
    typedef struct packed {
        logic [lds_pkg::SLEEP_CNT_W-1:0] cnt;
        logic tick;
    } lds_tmr_s;

    lds_tmr_s st;
    lds_tmr_s next_st;
    logic [lds_pkg::SLEEP_CNT_W-1:0] limit;

    always_comb begin
        unique case (i_sel)
            lds_pkg::SLP_SEL_512: limit = lds_pkg::SLEEP_CNT_W'(CYC_512 - 1);
            lds_pkg::SLP_SEL_64: limit = lds_pkg::SLEEP_CNT_W'(CYC_64 - 1);
            lds_pkg::SLP_SEL_8: limit = lds_pkg::SLEEP_CNT_W'(CYC_8 - 1);
            default: limit = lds_pkg::SLEEP_CNT_W'(CYC_1 - 1);
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!i_run) begin
            next_st.cnt = '0;
        end else if (st.cnt >= limit) begin
            next_st.cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;

    a_tick_only_run: assert property (@(posedge i_clk) disable iff (i_srst)
        o_tick |-> $past(i_run)) else $error("wake tick without run");
endmodule : lds_wake_timer
`default_nettype wire

// ---- hw/lds_top.sv ----
/*
 * led dimming and power-mode sequencer with a two-way sleep-control pin.
 * assumes configuration arrives as plain ports from an i2c slave on i_clk,
 * button status from a sensing front end on i_clk; gpio pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module lds_top #(
    parameter int NUM_GPIO = lds_pkg::NUM_GPIO,
    parameter int CYC_512 = lds_pkg::SLEEP_CYC_512,
    parameter int CYC_64 = lds_pkg::SLEEP_CYC_64,
    parameter int CYC_8 = lds_pkg::SLEEP_CYC_8,
    parameter int CYC_1 = lds_pkg::SLEEP_CYC_1
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire lds_pkg::lds_cfg_s i_cfg,
    input wire logic i_addr_wr,
    input wire logic [6:0] i_addr_data,
    input wire logic [NUM_GPIO-1:0] i_button,
    input wire logic i_scan_done,
    input wire logic [NUM_GPIO-1:0] i_gpio_in,
    output logic [NUM_GPIO-1:0] o_gpio_out,
    output logic [NUM_GPIO-1:0] o_gpio_oe,
    output logic [NUM_GPIO-1:0] o_gpio_avail,
    output logic o_sense_pwr,
    output logic o_scan_req,
    output logic o_asleep,
    output logic [6:0] o_i2c_addr
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] pwm_cnt;
        logic [3:0] duty_act;
        lds_pkg::lds_dim_e mode_act;
        logic [NUM_GPIO-1:0] btn_prev;
        logic [NUM_GPIO-1:0] lit;
        lds_pkg::lds_state_e pst;
        logic [NUM_GPIO-1:0] gpio_out;
        logic [NUM_GPIO-1:0] gpio_oe;
        logic [NUM_GPIO-1:0] oe_d1;
        logic [NUM_GPIO-1:0] oe_d2;
        logic [NUM_GPIO-1:0] avail;
        logic sense_pwr;
        logic scan_req;
        logic asleep;
        logic [6:0] addr;
    } lds_top_s;

    lds_top_s st;
    lds_top_s next_st;

    // pins cross in from the outside world: two flops before any use
    logic [NUM_GPIO-1:0] gpio_meta;
    logic [NUM_GPIO-1:0] gpio_sync;
    logic tmr_tick;
    logic pwm_wave;
    logic any_press;
    logic gpio_wake;
    logic sctl_low;
    logic [NUM_GPIO-1:0] sctl_mask;
    logic [NUM_GPIO-1:0] drv_mask;
    logic [NUM_GPIO-1:0] pwm_pins;
    logic [NUM_GPIO-1:0] static_pins;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            gpio_meta <= '1;
            gpio_sync <= '1;
        end else begin
            gpio_meta <= i_gpio_in;
            gpio_sync <= gpio_meta;
        end
    end

    lds_wake_timer #(
        .CYC_512(CYC_512),
        .CYC_64(CYC_64),
        .CYC_8(CYC_8),
        .CYC_1(CYC_1)
    ) u_timer (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_run(st.pst == lds_pkg::LDS_ST_SLEEP),
        .i_sel(i_cfg.sleep_sel),
        .o_tick(tmr_tick)
    );

    // ------------------------------------------------------------
    // sleep-control pin select
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_GPIO; gi++) begin : g_sel
            assign sctl_mask[gi] = i_cfg.sctl_en && (i_cfg.sctl_pin == lds_pkg::GPIO_IDX_W'(gi));
        end
    endgenerate

    assign pwm_wave = (st.pwm_cnt < st.duty_act);
    assign any_press = |(i_button & ~sctl_mask);
    // the synced level lags our own drive by two cycles: a pin we just let go still reads our low,
    // so it stays masked until the synchroniser has seen the released level
    assign drv_mask = st.gpio_oe | st.oe_d1 | st.oe_d2;
    // gpio wake: any non-sleep-pin input going low, which the interrupt level models
    assign gpio_wake = |(~gpio_sync & ~sctl_mask & ~drv_mask);
    // sleep pin only wakes while it is an input, not while signalling a press
    assign sctl_low = |(sctl_mask & ~gpio_sync & ~drv_mask);
    assign pwm_pins = i_cfg.pwm_en & i_cfg.use_pwm & st.lit & ~sctl_mask;
    assign static_pins = i_cfg.pwm_en & ~(i_cfg.use_pwm & st.lit) & ~sctl_mask;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.scan_req = 1'b0;

        // pwm counter; new duty and mode latch only at the wrap
        if (st.pwm_cnt == lds_pkg::DUTY_PERIOD - 4'h1) begin
            next_st.pwm_cnt = '0;
            next_st.duty_act = i_cfg.duty;
            next_st.mode_act = i_cfg.dim_mode;
        end else begin
            next_st.pwm_cnt = st.pwm_cnt + 4'h1;
        end

        // per-pin dimming state, one mode for all pins
        next_st.btn_prev = i_button;
        for (int i = 0; i < NUM_GPIO; i++) begin
            unique case (st.mode_act)
                lds_pkg::LDS_DIM_FOLLOW: next_st.lit[i] = 1'b1;
                lds_pkg::LDS_DIM_FLASH: next_st.lit[i] = i_button[i];
                lds_pkg::LDS_DIM_HOLD: begin
                    if (st.btn_prev[i] && !i_button[i]) begin
                        next_st.lit[i] = 1'b1;
                    end
                end
                lds_pkg::LDS_DIM_TOGGLE: begin
                    if (st.btn_prev[i] != i_button[i]) begin
                        next_st.lit[i] = ~st.lit[i];
                    end
                end
            endcase
        end

        // pin drivers
        next_st.oe_d1 = st.gpio_oe;
        next_st.oe_d2 = st.oe_d1;
        for (int i = 0; i < NUM_GPIO; i++) begin
            next_st.avail[i] = ~sctl_mask[i];
            if (sctl_mask[i]) begin
                // open-drain press signal toward the host
                next_st.gpio_out[i] = 1'b0;
                next_st.gpio_oe[i] = i_cfg.sctl_irq_en && any_press;
            end else if (i_cfg.pwm_en[i]) begin
                next_st.gpio_oe[i] = 1'b1;
                if (i_cfg.use_pwm[i] && st.lit[i]) begin
                    next_st.gpio_out[i] = pwm_wave;
                end else begin
                    next_st.gpio_out[i] = i_cfg.static_high[i];
                end
            end else begin
                next_st.gpio_out[i] = 1'b0;
                next_st.gpio_oe[i] = 1'b0;
            end
        end

        // power-mode sequencer
        unique case (st.pst)
            lds_pkg::LDS_ST_ACTIVE: begin
                if (i_cfg.deep_en && !sctl_low) begin
                    next_st.pst = lds_pkg::LDS_ST_DEEP;
                end else if (i_cfg.sleep_en && !sctl_low) begin
                    next_st.pst = lds_pkg::LDS_ST_SLEEP;
                end
            end
            lds_pkg::LDS_ST_SLEEP: begin
                if (gpio_wake || sctl_low || !i_cfg.sleep_en) begin
                    next_st.pst = lds_pkg::LDS_ST_ACTIVE;
                end else if (tmr_tick) begin
                    next_st.pst = lds_pkg::LDS_ST_SCAN;
                    next_st.scan_req = 1'b1;
                end
            end
            lds_pkg::LDS_ST_SCAN: begin
                if (gpio_wake || sctl_low) begin
                    next_st.pst = lds_pkg::LDS_ST_ACTIVE;
                end else if (i_scan_done) begin
                    next_st.pst = lds_pkg::LDS_ST_SLEEP;
                end
            end
            lds_pkg::LDS_ST_DEEP: begin
                // the wake timer is stopped here, so only a pin or clearing deep_en can end it
                if (gpio_wake || sctl_low || !i_cfg.deep_en) begin
                    next_st.pst = lds_pkg::LDS_ST_ACTIVE;
                end
            end
            default: next_st.pst = lds_pkg::LDS_ST_ACTIVE;
        endcase
        next_st.sense_pwr = (next_st.pst == lds_pkg::LDS_ST_ACTIVE) || (next_st.pst == lds_pkg::LDS_ST_SCAN);
        next_st.asleep = (next_st.pst == lds_pkg::LDS_ST_SLEEP) || (next_st.pst == lds_pkg::LDS_ST_DEEP);

        // address may be rewritten only while unlocked
        if (i_addr_wr && !i_cfg.i2c_addr_lock) begin
            next_st.addr = i_addr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st <= '0;
            st.pst <= lds_pkg::LDS_ST_ACTIVE;
            st.sense_pwr <= 1'b1;
            st.addr <= lds_pkg::I2C_ADDR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_gpio_out = st.gpio_out;
    assign o_gpio_oe = st.gpio_oe;
    assign o_gpio_avail = st.avail;
    assign o_sense_pwr = st.sense_pwr;
    assign o_scan_req = st.scan_req;
    assign o_asleep = st.asleep;
    assign o_i2c_addr = st.addr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_timed_wake;
        st.pst == lds_pkg::LDS_ST_SLEEP && tmr_tick && !gpio_wake && !sctl_low && i_cfg.sleep_en;
    endsequence
    sequence s_scan_state;
        o_scan_req && st.pst == lds_pkg::LDS_ST_SCAN;
    endsequence

    // power sequencing
    a_timed_scan_once: assert property (@(posedge i_clk) disable iff (i_srst)
        s_timed_wake |=> s_scan_state ##1 !o_scan_req) else $error("timed wake gave no single scan");
    a_scan_powered: assert property (@(posedge i_clk) disable iff (i_srst)
        o_scan_req |-> o_sense_pwr) else $error("scan without sensing power");
    a_deep_no_timer: assert property (@(posedge i_clk) disable iff (i_srst)
        st.pst == lds_pkg::LDS_ST_DEEP && !gpio_wake && !sctl_low && i_cfg.deep_en
        |=> st.pst == lds_pkg::LDS_ST_DEEP) else $error("deep sleep left without pin");
    a_sleep_entry: assert property (@(posedge i_clk) disable iff (i_srst)
        st.pst == lds_pkg::LDS_ST_ACTIVE && i_cfg.sleep_en && !i_cfg.deep_en && !sctl_low
        |=> o_asleep) else $error("sleep not entered");
    a_gpio_wakes_sleep: assert property (@(posedge i_clk) disable iff (i_srst)
        st.pst == lds_pkg::LDS_ST_SLEEP && gpio_wake |=> st.pst == lds_pkg::LDS_ST_ACTIVE)
        else $error("gpio did not wake");
    a_sctl_wakes: assert property (@(posedge i_clk) disable iff (i_srst)
        st.pst != lds_pkg::LDS_ST_ACTIVE && sctl_low |=> st.pst == lds_pkg::LDS_ST_ACTIVE)
        else $error("sleep pin did not wake");
    a_active_sense_pwr: assert property (@(posedge i_clk) disable iff (i_srst)
        st.pst == lds_pkg::LDS_ST_ACTIVE |-> o_sense_pwr) else $error("sensing off in active");

    // pins and dimming
    a_duty_boundary: assert property (@(posedge i_clk) disable iff (i_srst)
        st.pwm_cnt != 4'h0 |-> $stable(st.duty_act) && $stable(st.mode_act))
        else $error("duty changed mid period");
    a_flash_follow: assert property (@(posedge i_clk) disable iff (i_srst)
        st.mode_act == lds_pkg::LDS_DIM_FLASH |=> st.lit == $past(i_button))
        else $error("flash does not follow button");
    a_toggle_edge: assert property (@(posedge i_clk) disable iff (i_srst)
        st.mode_act == lds_pkg::LDS_DIM_TOGGLE |=> st.lit == ($past(st.lit) ^ $past(st.btn_prev) ^ $past(i_button)))
        else $error("toggle missed a button edge");
    a_pwm_shared: assert property (@(posedge i_clk) disable iff (i_srst)
        |pwm_pins |=> (o_gpio_out & $past(pwm_pins)) == ($past(pwm_pins) & {NUM_GPIO{$past(pwm_wave)}}))
        else $error("pwm pins disagree");
    a_static_level: assert property (@(posedge i_clk) disable iff (i_srst)
        |static_pins |=> (o_gpio_out & $past(static_pins)) == ($past(static_pins) & $past(i_cfg.static_high)))
        else $error("static level wrong");
    a_press_signal: assert property (@(posedge i_clk) disable iff (i_srst)
        i_cfg.sctl_irq_en && any_press |=> (o_gpio_oe & $past(sctl_mask)) == $past(sctl_mask)
        && (o_gpio_out & $past(sctl_mask)) == '0) else $error("press not signalled");
    a_sctl_withdrawn: assert property (@(posedge i_clk) disable iff (i_srst)
        i_cfg.sctl_en && !i_srst |=> !o_gpio_avail[$past(i_cfg.sctl_pin)])
        else $error("sleep pin still general");

    // address
    a_addr_locked: assert property (@(posedge i_clk) disable iff (i_srst)
        i_cfg.i2c_addr_lock |=> $stable(o_i2c_addr)) else $error("locked address changed");
endmodule : lds_top
`default_nettype wire

// ---- tb/lds_host_model.sv ----
/*
 * host-side model of the gpio wires: pull-ups plus a host that can pull lines low.
 * assumes the device drives only while its enable is high; a released line reads high.
 */
`timescale 1ns/1ps
`default_nettype none
module lds_host_model #(
    parameter int N = 10
) (
    input wire logic [N-1:0] i_gpio_out,
    input wire logic [N-1:0] i_gpio_oe,
    input wire logic [N-1:0] i_pull_low,
    output logic [N-1:0] o_gpio_in
);
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    // an enabled device drive wins; else a host pull low wins, as on the sleep line ahead of a transfer; otherwise the pull-up wins
    always_comb begin
        for (int k = 0; k < N; k++) begin
            o_gpio_in[k] = i_gpio_oe[k] ? i_gpio_out[k] : !i_pull_low[k];
        end
    end
endmodule : lds_host_model
`default_nettype wire

// ---- tb/lds_top_bench.sv ----
/*
 * self-checking bench for the led dimming and sleep control block.
 * assumes shortened wake intervals and a host model resolving the gpio wires.
 */
`timescale 1ns/1ps
`default_nettype none
module lds_top_bench;
    localparam int N = 10;
    localparam int CYC[4] = '{20, 40, 60, 80};
    logic clk, srst, addr_wr, scan_done;
    lds_pkg::lds_cfg_s cfg;
    logic [6:0] addr_data, i2c_addr;
    logic [N-1:0] button, pull_low, gpio_in, gpio_out, gpio_oe, avail;
    logic sense_pwr, scan_req, asleep;
    int miscompares = 0;
    int cmp_count = 0;

    lds_top #(.NUM_GPIO(N), .CYC_512(CYC[0]), .CYC_64(CYC[1]), .CYC_8(CYC[2]), .CYC_1(CYC[3])) lds_top_i (
        .i_clk(clk), .i_srst(srst), .i_cfg(cfg), .i_addr_wr(addr_wr), .i_addr_data(addr_data),
        .i_button(button), .i_scan_done(scan_done), .i_gpio_in(gpio_in), .o_gpio_out(gpio_out),
        .o_gpio_oe(gpio_oe), .o_gpio_avail(avail), .o_sense_pwr(sense_pwr), .o_scan_req(scan_req),
        .o_asleep(asleep), .o_i2c_addr(i2c_addr));
    lds_host_model #(.N(N)) lds_host_model_i (
        .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe), .i_pull_low(pull_low), .o_gpio_in(gpio_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // sel 0 waits on the sleep flag, 1 on the scan request; a used-up bound ends the run
    task automatic wait_on(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (((sel == 0) ? asleep : scan_req) !== v) begin
            if (n == lim) begin
                miscompares++;
                $display("mismatch wait %0d expected %0b seen timeout", sel, v);
                report_and_stop();
            end
            step(1);
            n++;
        end
    endtask : wait_on

    task automatic set_mode(input lds_pkg::lds_dim_e m);
        cfg.dim_mode = m;
        step(20);
    endtask : set_mode

    task automatic press(input logic v);
        button[0] = v;
        step(3);
    endtask : press

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("sense power", 1, sense_pwr);
        chk("asleep", 0, asleep);
        chk("gpio oe", 0, gpio_oe);
        chk("address", 7'h00, i2c_addr);
        $display("test reset done");
    endtask : t_reset

    task automatic t_addr();
        addr_data = 7'h2a;
        addr_wr = 1'b1;
        step(1);
        addr_wr = 1'b0;
        step(1);
        chk("address", 7'h2a, i2c_addr);
        cfg.i2c_addr_lock = 1'b1;
        addr_data = 7'h15;
        addr_wr = 1'b1;
        step(1);
        addr_wr = 1'b0;
        step(1);
        chk("address locked", 7'h2a, i2c_addr);
        $display("test address done");
    endtask : t_addr

    task automatic t_pwm();
        int hi;
        int duty[3] = '{0, 8, 15};
        cfg.pwm_en = 10'h00f;
        cfg.use_pwm = 10'h009;
        cfg.static_high = 10'h002;
        for (int d = 0; d < 3; d++) begin
            cfg.duty = 4'(duty[d]);
            step(40);
            hi = 0;
            for (int c = 0; c < 15; c++) begin
                hi += int'(gpio_out[0] === 1'b1);
                chk("shared wave", gpio_out[0], gpio_out[3]);
                chk("static high", 1, gpio_out[1]);
                chk("static low", 0, gpio_out[2]);
                step(1);
            end
            chk("duty highs", duty[d], hi);
        end
        $display("test pwm done");
    endtask : t_pwm

    task automatic t_modes();
        logic v0;
        cfg.duty = 4'hf;
        set_mode(lds_pkg::LDS_DIM_FOLLOW);
        chk("follow lit", 1, gpio_out[0]);
        set_mode(lds_pkg::LDS_DIM_FLASH);
        chk("flash off", 0, gpio_out[0]);
        press(1'b1);
        chk("flash on", 1, gpio_out[0]);
        chk("mode common", 0, gpio_out[3]);
        press(1'b0);
        chk("flash off", 0, gpio_out[0]);
        set_mode(lds_pkg::LDS_DIM_HOLD);
        press(1'b1);
        press(1'b0);
        chk("hold after release", 1, gpio_out[0]);
        press(1'b1);
        chk("hold kept", 1, gpio_out[0]);
        press(1'b0);
        set_mode(lds_pkg::LDS_DIM_TOGGLE);
        v0 = gpio_out[0];
        press(1'b1);
        chk("toggle rise", !v0, gpio_out[0]);
        press(1'b0);
        chk("toggle fall", v0, gpio_out[0]);
        cfg.pwm_en = '0;
        step(20);
        $display("test modes done");
    endtask : t_modes

    task automatic t_sleep();
        int n;
        for (int k = 0; k < 4; k++) begin
            cfg.sleep_sel = 2'(k);
            cfg.sleep_en = 1'b1;
            wait_on(0, 1'b1, 20, n);
            chk("sensing off", 0, sense_pwr);
            // interval cycles asleep, then one more for the registered scan request
            wait_on(1, 1'b1, 200, n);
            chk("interval", CYC[k] + 1, n);
            chk("scan power", 1, sense_pwr);
            scan_done = 1'b1;
            step(1);
            scan_done = 1'b0;
            step(2);
            chk("back asleep", 1, asleep);
            pull_low[5] = 1'b1;
            wait_on(0, 1'b0, 8, n);
            cfg.sleep_en = 1'b0;
            pull_low[5] = 1'b0;
            step(4);
        end
        $display("test sleep done");
    endtask : t_sleep

    task automatic t_deep();
        int n;
        cfg.deep_en = 1'b1;
        cfg.sleep_en = 1'b1;
        wait_on(0, 1'b1, 20, n);
        for (int c = 0; c < 200; c++) begin
            if (scan_req === 1'b1) chk("deep scan", 0, scan_req);
            step(1);
        end
        chk("deep asleep", 1, asleep);
        pull_low[6] = 1'b1;
        wait_on(0, 1'b0, 8, n);
        cfg.deep_en = 1'b0;
        cfg.sleep_en = 1'b0;
        step(2);
        pull_low[6] = 1'b0;
        step(6);
        $display("test deep done");
    endtask : t_deep

    // reset while asleep must bring back the idle state
    task automatic t_mid_reset();
        int n;
        cfg.sleep_en = 1'b1;
        wait_on(0, 1'b1, 20, n);
        srst = 1'b1;
        cfg.sleep_en = 1'b0;
        step(2);
        srst = 1'b0;
        step(1);
        t_reset();
    endtask : t_mid_reset

    task automatic t_sctl();
        int n;
        cfg.sctl_en = 1'b1;
        cfg.sctl_pin = 4'h4;
        cfg.sleep_en = 1'b1;
        step(4);
        chk("available pins", 10'h3ef, avail);
        wait_on(0, 1'b1, 20, n);
        pull_low[4] = 1'b1;
        wait_on(0, 1'b0, 8, n);
        pull_low[4] = 1'b0;
        cfg.sctl_irq_en = 1'b1;
        button[2] = 1'b1;
        step(3);
        chk("press drive", 1, gpio_oe[4]);
        chk("press level", 0, gpio_out[4]);
        button[2] = 1'b0;
        step(3);
        chk("press released", 0, gpio_oe[4]);
        chk("no self wake", 1, asleep);
        $display("test sleep pin done");
    endtask : t_sctl

    initial begin
        srst = 1'b1;
        cfg = '0;
        addr_wr = 1'b0;
        addr_data = 7'h00;
        button = '0;
        scan_done = 1'b0;
        pull_low = '0;
        repeat (12) @(posedge clk);
        #1;
        srst = 1'b0;
        step(1);
        t_reset();
        t_addr();
        t_pwm();
        t_modes();
        t_sleep();
        t_deep();
        t_mid_reset();
        t_sctl();
        report_and_stop();
    end
endmodule : lds_top_bench
`default_nettype wire
